/* File: pfrc_defs.svh */
// register indices, field positions, reset values and timing constants
// assumes inclusion by bare name from every design file that needs them
`ifndef PFRC_DEFS_SVH
`define PFRC_DEFS_SVH

// register indices, byte address is four times the index
`define PFRC_IDX_CTL 8'h08
`define PFRC_IDX_PWON 8'h09
`define PFRC_IDX_CFG 8'h0C
`define PFRC_IDX_STS 8'h0D
`define PFRC_IDX_CLR 8'h0E
`define PFRC_IDX_EN 8'h0F

// power-on control register
`define PFRC_PWON_RST 8'h87
`define PFRC_B_WAKE 7
`define PFRC_B_PRIOR 6
`define PFRC_B_POL_HI 5
`define PFRC_B_POL_LO 4
`define PFRC_B_LEGACY 3
`define PFRC_B_CB_HI 2
`define PFRC_B_CB_LO 0

// miscellaneous control register
`define PFRC_B_CROWBAR 4

// configuration register
`define PFRC_B_EXTSEL 0
`define PFRC_B_EXTMUX 1
`define PFRC_B_BMODE 2
`define PFRC_CFG_W 3

// interrupt status, clear and enable layout
`define PFRC_I_CROWBAR 0
`define PFRC_I_WAKE 1
`define PFRC_I_PRESS 2
`define PFRC_IRQ_W 3

// resume policies
`define PFRC_POL_S3 2'h0
`define PFRC_POL_RTC 2'h1
`define PFRC_POL_LAST 2'h2
`define PFRC_POL_LAST_RTC 2'h3

// timing
`define PFRC_CLK_HZ 25000000
`define PFRC_CLK_NS 40
`define PFRC_SEC_CYC (`PFRC_CLK_HZ)
`define PFRC_PULSE_NS 10000
`define PFRC_PULSE_CYC ((`PFRC_PULSE_NS + `PFRC_CLK_NS - 1) / `PFRC_CLK_NS)
`define PFRC_OVR_SEC 4'h4

`endif

/* File: pfrc_pkg.sv */
// types shared by the power-fail resume controller
// assumes nothing beyond a SystemVerilog compiler
package pfrc_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pfrc_apb_req_s;

	typedef struct packed {
		logic stby;
		logic vdd;
		logic btn_n;
		logic s3;
		logic s5;
		logic rtc;
	} pfrc_pins_s;

	typedef enum logic [1:0] {
		PS_OFF,
		PS_ARM,
		PS_ON,
		PS_LOCK
	} pfrc_pwr_e;

endpackage

/* File: pfrc_sync.sv */
// two-flop synchroniser for a group of pin levels
// assumes inputs asynchronous to mclk_i
`timescale 1ns/1ps
module pfrc_sync #(
	parameter int unsigned W = 6
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

/* File: pfrc_tick.sv */
// one-cycle enable pulse every CYC clocks, restartable
// assumes CYC of at least two
`timescale 1ns/1ps
module pfrc_tick #(
	parameter int unsigned CYC = 25000000
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// control
	input wire logic clr_i,
	output logic tick_o
);
	localparam int unsigned W = $clog2(CYC);
	logic [W-1:0] cnt_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || clr_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else if (cnt_q == W'(CYC - 1)) begin
			cnt_q <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= W'(cnt_q + 1'b1);
			tick_o <= 1'b0;
		end
	end
endmodule

/* File: pfrc_top.sv */
// power-fail resume controller: main supply control, button and crowbar
// assumes an APB master on mclk_i and asynchronous power pins
`timescale 1ns/1ps
`include "pfrc_defs.svh"
module pfrc_top #(
	parameter int unsigned SEC_CYC = `PFRC_SEC_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire pfrc_pkg::pfrc_apb_req_s apb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// power pins
	input wire logic standby_good_i,
	input wire logic main_power_good_i,
	input wire logic power_button_in_n_i,
	input wire logic chipset_sleep_s3_in_i,
	input wire logic chipset_sleep_s5_in_i,
	input wire logic rtc_alarm_i,
	// supply control
	output logic main_power_on_out_o,
	output logic button_pulse_out_o,
	// interrupt
	output logic irq_o
);
	import pfrc_pkg::*;

	localparam logic [7:0] PWON_RST = `PFRC_PWON_RST;
	localparam logic [15:0] PULSE_CYC = 16'(`PFRC_PULSE_CYC);

	function automatic logic [7:0] reg_idx(input logic [11:0] a);
		reg_idx = a[9:2];
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		logic [7:0] i;
		i = reg_idx(a);
		is_mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			((i == `PFRC_IDX_CTL) || (i == `PFRC_IDX_PWON) ||
			(i == `PFRC_IDX_CFG) || (i == `PFRC_IDX_STS) ||
			(i == `PFRC_IDX_CLR) || (i == `PFRC_IDX_EN));
	endfunction

	function automatic logic [3:0] crowbar_secs(input logic [2:0] sel);
		crowbar_secs = 4'({1'b0, sel} + 4'h1);
	endfunction

	function automatic logic resume_on(
		input logic [1:0] pol,
		input logic ext,
		input logic s3,
		input logic prior,
		input logic rtc
	);
		case (pol)
			`PFRC_POL_S3: resume_on = ext & s3;
			`PFRC_POL_RTC: resume_on = (ext & s3) | rtc;
			`PFRC_POL_LAST: resume_on = prior;
			`PFRC_POL_LAST_RTC: resume_on = prior | rtc;
			default: resume_on = 1'b0;
		endcase
	endfunction

	// pin synchronisation
	pfrc_pins_s pin_raw;
	pfrc_pins_s pin_s;
	pfrc_pins_s pin_q;

	assign pin_raw = '{stby: standby_good_i, vdd: main_power_good_i,
		btn_n: power_button_in_n_i, s3: chipset_sleep_s3_in_i,
		s5: chipset_sleep_s5_in_i, rtc: rtc_alarm_i};

	pfrc_sync #(
		.W($bits(pfrc_pins_s))
	) u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_q <= '0;
		end else begin
			pin_q <= pin_s;
		end
	end

	// register state
	logic wake_q;
	logic prior_q;
	logic [1:0] pol_q;
	logic legacy_q;
	logic [2:0] cbsel_q;
	logic crowbar_q;
	logic [`PFRC_CFG_W-1:0] cfg_q;
	logic [`PFRC_IRQ_W-1:0] sts_q;
	logic [`PFRC_IRQ_W-1:0] en_q;
	logic rtc_q;

	// power control state
	pfrc_pwr_e state_q;
	logic [3:0] cb_cnt_q;
	logic [3:0] hold_q;
	logic [15:0] pcnt_q;
	logic tick;

	// events
	logic stby_rise;
	logic stby_fall;
	logic press_ev;
	logic sleep_ev;
	logic ovr_ev;
	logic wake_on;
	logic start_on;
	logic cb_exp;
	logic go_off;
	logic pulse_go;

	assign stby_rise = pin_s.stby & ~pin_q.stby;
	assign stby_fall = ~pin_s.stby & pin_q.stby;
	assign press_ev = ~pin_s.btn_n & pin_q.btn_n;
	assign sleep_ev = (pin_s.s3 & ~pin_q.s3) | (pin_s.s5 & ~pin_q.s5);
	assign ovr_ev = tick & ~pin_s.btn_n & (hold_q == 4'(`PFRC_OVR_SEC - 4'h1));
	assign wake_on = resume_on(pol_q, cfg_q[`PFRC_B_EXTSEL], pin_s.s3,
		prior_q, rtc_q);
	// policy looked at only on the standby return edge
	assign start_on = (stby_rise & wake_on) |
		((state_q == PS_OFF) & press_ev & ~stby_rise);
	// at-or-past compare so a shorter timeout written while armed still fires
	assign cb_exp = (state_q == PS_ARM) & tick & ~pin_s.vdd &
		(4'(cb_cnt_q + 4'h1) >= crowbar_secs(cbsel_q));
	// plain press cuts power only in legacy mode
	assign go_off = (state_q == PS_ON) &
		(sleep_ev | ovr_ev | (legacy_q & press_ev));
	assign pulse_go = stby_rise & wake_on & ~cfg_q[`PFRC_B_BMODE];

	pfrc_tick #(
		.CYC(SEC_CYC)
	) u_tick (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clr_i(start_on | cb_exp),
		.tick_o(tick)
	);

	// power state machine
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_q <= PS_OFF;
		end else if (stby_fall) begin
			state_q <= PS_OFF;
		end else begin
			case (state_q)
				PS_OFF: begin
					if (start_on) begin
						state_q <= PS_ARM;
					end
				end
				PS_ARM: begin
					if (pin_s.vdd) begin
						state_q <= PS_ON;
					end else if (cb_exp) begin
						state_q <= PS_LOCK;
					end
				end
				PS_ON: begin
					if (go_off) begin
						state_q <= PS_OFF;
					end
				end
				PS_LOCK: begin
					if (tick) begin
						state_q <= PS_OFF;
					end
				end
				default: state_q <= PS_OFF;
			endcase
		end
	end

	// main supply output, low means on
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			main_power_on_out_o <= 1'b1;
		end else if (stby_fall || cb_exp || go_off) begin
			main_power_on_out_o <= 1'b1;
		end else if (start_on) begin
			main_power_on_out_o <= 1'b0;
		end
	end

	// crowbar and override counters
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || start_on) begin
			cb_cnt_q <= 4'h0;
		end else if (state_q == PS_ARM && tick) begin
			cb_cnt_q <= 4'(cb_cnt_q + 4'h1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || pin_s.btn_n) begin
			hold_q <= 4'h0;
		end else if (tick && hold_q != `PFRC_OVR_SEC) begin
			hold_q <= 4'(hold_q + 4'h1);
		end
	end

	// button output pulse
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pcnt_q <= 16'h0000;
			button_pulse_out_o <= 1'b0;
		end else if (pulse_go) begin
			pcnt_q <= PULSE_CYC;
			button_pulse_out_o <= 1'b1;
		end else if (pcnt_q != 16'h0000) begin
			pcnt_q <= 16'(pcnt_q - 16'h0001);
			button_pulse_out_o <= (pcnt_q != 16'h0001);
		end
	end

	// power-fail capture
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			prior_q <= PWON_RST[`PFRC_B_PRIOR];
			rtc_q <= 1'b0;
		end else if (stby_fall) begin
			prior_q <= ~main_power_on_out_o;
			rtc_q <= pin_s.rtc;
		end else if (!pin_s.stby && pin_s.rtc) begin
			rtc_q <= 1'b1;
		end
	end

	// apb slave, one wait state
	logic acc;
	logic wr_en;
	logic [7:0] widx;
	logic [31:0] rd_d;
	logic [7:0] wdat;

	assign acc = apb_i.psel & apb_i.penable & ~pready_o;
	assign wr_en = apb_i.psel & apb_i.penable & pready_o & apb_i.pwrite &
		is_mapped(apb_i.paddr);
	assign widx = reg_idx(apb_i.paddr);
	assign wdat = apb_i.pwdata[7:0];

	always_comb begin
		rd_d = 32'h0000_0000;
		case (reg_idx(apb_i.paddr))
			`PFRC_IDX_PWON: rd_d[7:0] = {wake_q, prior_q, pol_q, legacy_q, cbsel_q};
			`PFRC_IDX_CTL: rd_d[`PFRC_B_CROWBAR] = crowbar_q;
			`PFRC_IDX_CFG: rd_d[`PFRC_CFG_W-1:0] = cfg_q;
			`PFRC_IDX_STS: rd_d[`PFRC_IRQ_W-1:0] = sts_q;
			`PFRC_IDX_EN: rd_d[`PFRC_IRQ_W-1:0] = en_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= acc;
			pslverr_o <= acc & ~is_mapped(apb_i.paddr);
			prdata_o <= (acc && !apb_i.pwrite && is_mapped(apb_i.paddr)) ?
				rd_d : 32'h0000_0000;
		end
	end

	// power-on control register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wake_q <= PWON_RST[`PFRC_B_WAKE];
			pol_q <= PWON_RST[`PFRC_B_POL_HI:`PFRC_B_POL_LO];
			legacy_q <= PWON_RST[`PFRC_B_LEGACY];
			cbsel_q <= PWON_RST[`PFRC_B_CB_HI:`PFRC_B_CB_LO];
		end else begin
			if (stby_rise) begin
				wake_q <= 1'b1;
			end else if (wr_en && widx == `PFRC_IDX_PWON && wdat[`PFRC_B_WAKE]) begin
				wake_q <= 1'b0;
			end
			if (wr_en && widx == `PFRC_IDX_PWON) begin
				pol_q <= wdat[`PFRC_B_POL_HI:`PFRC_B_POL_LO];
				legacy_q <= wdat[`PFRC_B_LEGACY];
				cbsel_q <= wdat[`PFRC_B_CB_HI:`PFRC_B_CB_LO];
			end
		end
	end

	// crowbar flag, configuration, interrupt registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			crowbar_q <= 1'b0;
		end else if (cb_exp) begin
			crowbar_q <= 1'b1;
		end else if (wr_en && widx == `PFRC_IDX_CTL && wdat[`PFRC_B_CROWBAR]) begin
			crowbar_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cfg_q <= '0;
			en_q <= '0;
		end else if (wr_en && widx == `PFRC_IDX_CFG) begin
			cfg_q <= wdat[`PFRC_CFG_W-1:0];
		end else if (wr_en && widx == `PFRC_IDX_EN) begin
			en_q <= wdat[`PFRC_IRQ_W-1:0];
		end
	end

	logic [`PFRC_IRQ_W-1:0] ev;
	logic [`PFRC_IRQ_W-1:0] clr;

	assign ev = {press_ev, stby_rise, cb_exp};
	assign clr = (wr_en && widx == `PFRC_IDX_CLR) ? wdat[`PFRC_IRQ_W-1:0] : '0;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sts_q <= '0;
			irq_o <= 1'b0;
		end else begin
			sts_q <= (sts_q & ~clr) | ev;
			irq_o <= |(sts_q & en_q);
		end
	end

	// checks
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_reset_value;
		@(posedge mclk_i) disable iff (1'b0)
		!rst_n_i |=> ({wake_q, prior_q, pol_q, legacy_q, cbsel_q} == PWON_RST);
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	property p_wake_set;
		stby_rise |=> wake_q;
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

	property p_wake_clr;
		(wr_en && widx == `PFRC_IDX_PWON && !stby_rise) |=>
			(wake_q == ($past(wake_q) && !$past(wdat[`PFRC_B_WAKE])));
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake flag write wrong");

	property p_prior_ro;
		(wr_en && !stby_fall) |=> $stable(prior_q);
	endproperty
	a_prior_ro: assert property (p_prior_ro) else $error("prior state written");

	property p_legacy_off;
		(state_q == PS_ON && legacy_q && press_ev && !stby_fall) |=>
			main_power_on_out_o && state_q == PS_OFF;
	endproperty
	a_legacy_off: assert property (p_legacy_off) else $error("legacy press kept power");

	property p_acpi_keep;
		(state_q == PS_ON && !legacy_q && press_ev && !sleep_ev && !ovr_ev &&
			!stby_fall && !main_power_on_out_o) |=> !main_power_on_out_o;
	endproperty
	a_acpi_keep: assert property (p_acpi_keep) else $error("plain press cut power");

	property p_pol_s3;
		(stby_rise && pol_q == `PFRC_POL_S3) |=>
			(main_power_on_out_o == !($past(cfg_q[`PFRC_B_EXTSEL]) && $past(pin_s.s3)));
	endproperty
	a_pol_s3: assert property (p_pol_s3) else $error("policy 00 wrong");

	property p_pol_last;
		(stby_rise && pol_q[1] && prior_q) |=> !main_power_on_out_o;
	endproperty
	a_pol_last: assert property (p_pol_last) else $error("policy 1x wrong");

	property p_no_pulse;
		(stby_rise && cfg_q[`PFRC_B_BMODE]) |=> !button_pulse_out_o [*2];
	endproperty
	a_no_pulse: assert property (p_no_pulse) else $error("pulse in wrong mode");

	property p_crowbar;
		cb_exp && !stby_fall |=> main_power_on_out_o && crowbar_q && state_q == PS_LOCK;
	endproperty
	a_crowbar: assert property (p_crowbar) else $error("crowbar not taken");

	property p_lockout;
		(state_q == PS_LOCK && !tick && !stby_rise) |=> main_power_on_out_o;
	endproperty
	a_lockout: assert property (p_lockout) else $error("press during lockout");
endmodule

/* File: pfrc_supply_model.sv */
// main supply model: answers the power-on request with power good
// assumes the request is active low and sampled on mclk_i
`timescale 1ns/1ps
module pfrc_supply_model (
	// clock
	input wire logic mclk_i,
	// request and behaviour
	input wire logic power_on_n_i,
	input wire logic dead_i,
	input wire logic [3:0] lag_i,
	// supply status
	output logic power_good_o
);
	logic [3:0] cnt_q = 4'h0;
	initial power_good_o = 1'b0;
	// good after a lag, lost at once when switched off
	always @(posedge mclk_i) begin
		if (power_on_n_i || dead_i) begin
			cnt_q <= 4'h0;
			power_good_o <= 1'b0;
		end else if (cnt_q < lag_i) begin
			cnt_q <= cnt_q + 4'h1;
		end else begin
			power_good_o <= 1'b1;
		end
	end
endmodule

/* File: power_fail_resume_control_test.sv */
// self-checking bench for the power-fail resume controller
// assumes pfrc_top, pfrc_pkg and the supply model are compiled first
`timescale 1ns/1ps
module power_fail_resume_control_test;
	import pfrc_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	pfrc_apb_req_s apb = '0;
	logic [31:0] prdata;
	logic pready, pslverr, pgood, main_power_on_out, pulse, irq;
	logic stby = 1'b0, btn_n = 1'b1, s3 = 1'b0, s5 = 1'b0, rtc = 1'b0, dead = 1'b0;
	logic [3:0] lag = 4'h2;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	logic [31:0] r;
	logic e, prior, ext, s3v, rtcv, bm, on;
	logic [1:0] pol;
	int n;
	pfrc_top #(.SEC_CYC(20)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(apb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .standby_good_i(stby),
		.main_power_good_i(pgood), .power_button_in_n_i(btn_n), .chipset_sleep_s3_in_i(s3),
		.chipset_sleep_s5_in_i(s5), .rtc_alarm_i(rtc), .main_power_on_out_o(main_power_on_out),
		.button_pulse_out_o(pulse), .irq_o(irq));
	pfrc_supply_model i_sup (.mclk_i(mclk_i), .power_on_n_i(main_power_on_out), .dead_i(dead),
		.lag_i(lag), .power_good_o(pgood));
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic clk(input int k);
		repeat (k) @(posedge mclk_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk_i);
		apb <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk_i);
		apb.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		apb <= '0;
		if (k >= 50) chk(0, 1, "bus hang");
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string m);
		bus(1'b0, a, 32'h0);
		chk(r, {24'h0, exp}, m);
	endtask
	task automatic press();
		btn_n <= 1'b0;
		clk(8);
		btn_n <= 1'b1;
		clk(8);
	endtask
	task automatic wait_out(input logic v, input int lim, output int k);
		k = 0;
		while (main_power_on_out !== v && k < lim) begin
			@(posedge mclk_i);
			k++;
		end
	endtask
	function automatic logic exp_on(logic [1:0] p, logic x, logic s, logic pr, logic rt);
		case (p)
			2'h0: return x & s;
			2'h1: return rt | (x & s);
			2'h2: return pr;
			default: return pr | rt;
		endcase
	endfunction
	initial begin
		void'($urandom(23531));
		clk(10);
		rst_n_i <= 1'b1;
		clk(2);
		rd(12'h024, 8'h87, "reset value");
		bus(1'b0, 12'h800, 32'h0);
		chk({r[7:0], e}, {8'h00, 1'b1}, "refused access");
		bus(1'b0, 12'h004, 32'h0);
		chk(e, 1'b1, "unmapped");
		prior = 1'b0;
		for (int i = 0; i < 12; i++) begin
			pol = i[1:0];
			{ext, s3v, rtcv, bm} = 4'($urandom());
			lag <= 4'($urandom());
			bus(1'b1, 12'h030, {29'h0, bm, ext, ext});
			bus(1'b1, 12'h024, {24'h0, 2'h0, pol, 4'h7});
			stby <= 1'b0;
			s3 <= s3v;
			rtc <= rtcv;
			clk(10);
			rtc <= 1'b0;
			clk(2);
			stby <= 1'b1;
			clk(10);
			on = exp_on(pol, ext, s3v, prior, rtcv);
			chk(main_power_on_out, !on, "resume output");
			chk(pulse, on & ~bm, "resume pulse");
			rd(12'h024, {1'b1, prior, pol, 4'h7}, "wake and prior");
			bus(1'b1, 12'h024, {24'h0, 1'b1, ~prior, pol, 4'h7});
			rd(12'h024, {1'b0, prior, pol, 4'h7}, "w1c and ro");
			clk(260);
			chk(pulse, 1'b0, "pulse ended");
			prior = on;
		end
		bus(1'b1, 12'h030, 32'h0);
		bus(1'b1, 12'h024, 32'h01);
		stby <= 1'b0;
		s3 <= 1'b0;
		clk(12);
		stby <= 1'b1;
		dead <= 1'b1;
		clk(10);
		bus(1'b1, 12'h03C, 32'h1);
		bus(1'b1, 12'h024, 32'h01);
		press();
		chk(main_power_on_out, 1'b0, "press turns on");
		wait_out(1'b1, 80, n);
		chk(n >= 16 && n <= 32, 1'b1, "crowbar interval");
		clk(2);
		chk(irq, 1'b1, "crowbar irq");
		rd(12'h020, 8'h10, "crowbar flag");
		dead <= 1'b0;
		press();
		chk(main_power_on_out, 1'b1, "press ignored in lock");
		clk(30);
		press();
		chk(main_power_on_out, 1'b0, "press accepted");
		bus(1'b1, 12'h038, 32'h1);
		bus(1'b1, 12'h020, 32'h10);
		rd(12'h020, 8'h00, "crowbar cleared");
		chk(irq, 1'b0, "irq cleared");
		clk(20);
		press();
		clk(10);
		chk(main_power_on_out, 1'b0, "plain press kept on");
		s3 <= 1'b1;
		clk(10);
		chk(main_power_on_out, 1'b1, "sleep cuts power");
		s3 <= 1'b0;
		clk(30);
		press();
		clk(20);
		bus(1'b1, 12'h024, 32'h09);
		press();
		clk(4);
		chk(main_power_on_out, 1'b1, "legacy press cuts power");
		press();
		clk(20);
		chk(main_power_on_out, 1'b0, "legacy press turns on");
		s5 <= 1'b1;
		clk(10);
		chk(main_power_on_out, 1'b1, "s5 cuts power");
		s5 <= 1'b0;
		bus(1'b1, 12'h024, 32'h01);
		press();
		clk(20);
		chk(main_power_on_out, 1'b0, "on before hold");
		btn_n <= 1'b0;
		clk(100);
		chk(main_power_on_out, 1'b1, "override cuts power");
		btn_n <= 1'b1;
		clk(4);
		conclude();
	end
endmodule
